// >>> rtl/ssa_pkg.sv
// Shared constants and types for the sampling converter parallel port
package ssa_pkg;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned CONV_TIME_NS = 3000;
  localparam int unsigned CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam int unsigned NUM_PAIRS = 3;
  localparam int unsigned NUM_CH = 6;
  localparam int unsigned DATA_W = 16;
  localparam logic [2:0] RST_PAIR_MASK = 3'h0;
  localparam logic [15:0] RST_DATA = 16'h0000;
  localparam logic [2:0] RST_CH = 3'h0;
  localparam int unsigned READ_IDLE = 2;
  typedef enum {SSA_IDLE, SSA_CONV} ssa_state_t;
  typedef enum {SSH_IDLE, SSH_START_LO, SSH_WAIT_BUSY, SSH_WAIT_DONE,
    SSH_READ_LO, SSH_READ_HI, SSH_GAP} ssh_state_t;
endpackage

// >>> rtl/ssa_port_if.sv
// Interface joining the converter and the host over the parallel port
`timescale 1ns/1ns
`default_nettype none
interface ssa_port_if;
  logic pair1_start_n;
  logic pair2_start_n;
  logic pair3_start_n;
  logic busy;
  logic cs_n;
  logic rd_n;
  logic interface_select;
  logic word_byte_sel;
  logic high_byte_first;
  logic [15:0] db_out;
  logic db_oe_n;
  modport dev (input pair1_start_n, input pair2_start_n,
    input pair3_start_n, output busy, input cs_n, input rd_n,
    input interface_select, input word_byte_sel, input high_byte_first,
    output db_out, output db_oe_n);
  modport host (output pair1_start_n, output pair2_start_n,
    output pair3_start_n, input busy, output cs_n, output rd_n,
    output interface_select, output word_byte_sel,
    output high_byte_first, input db_out, input db_oe_n);
endinterface
`default_nettype wire

// >>> rtl/ssa_rise_det.sv
// Rising edge detector for one start input per pair
`timescale 1ns/1ns
`default_nettype none
module ssa_rise_det
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] lvl_i,
  output logic [2:0] rise_o
);
  import ssa_pkg::*;
  logic [2:0] prev_r;
  // Level seen last cycle; start idles high
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prev_r <= 3'h7;
    else
      prev_r <= lvl_i;
  end
  // Low then high makes a start pulse
  genvar g;
  generate
    for (g = 0; g < NUM_PAIRS; g++)
    begin : g_rise
      assign rise_o[g] = lvl_i[g] & ~prev_r[g];
    end
  endgenerate
endmodule
`default_nettype wire

// >>> rtl/ssa_device.sv
// Converter end: start, busy timing, result store and parallel readout
`timescale 1ns/1ns
`default_nettype none
module ssa_device
(
  input wire logic clk_i,
  input wire logic rst_i,
  ssa_port_if.dev port,
  input wire logic [ssa_pkg::DATA_W*ssa_pkg::NUM_CH-1:0] sample_i,
  output logic track_o,
  output logic [2:0] conv_pairs_o
);
  import ssa_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Start edge detection
  logic [2:0] start_lvl;
  logic [2:0] start_rise;
  assign start_lvl = {port.pair3_start_n, port.pair2_start_n,
    port.pair1_start_n};
  ssa_rise_det u_rise
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lvl_i(start_lvl),
    .rise_o(start_rise)
  );

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencing
  ssa_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [2:0] pairs_r;
  logic busy_r;
  logic track_r;
  logic start_ok;
  logic conv_done;
  assign start_ok = (state_r == SSA_IDLE) && (|start_rise);
  assign conv_done = (state_r == SSA_CONV) && (cnt_r == CONV_LAST);

  // Busy high from start to the last conversion cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= SSA_IDLE;
      cnt_r <= '0;
      pairs_r <= RST_PAIR_MASK;
      busy_r <= 1'b0;
      track_r <= 1'b1;
    end
    else
    begin
      case (state_r)
        SSA_IDLE:
        begin
          if (start_ok)
          begin
            state_r <= SSA_CONV;
            cnt_r <= '0;
            pairs_r <= start_rise;
            busy_r <= 1'b1;
            track_r <= 1'b0;
          end
        end
        SSA_CONV:
        begin
          cnt_r <= cnt_r + 1'b1;
          if (conv_done)
          begin
            state_r <= SSA_IDLE;
            busy_r <= 1'b0;
            track_r <= 1'b1;
          end
        end
        default: state_r <= SSA_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result registers, loaded at end of conversion
  logic [DATA_W-1:0] res_r [NUM_CH];
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_res
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          res_r[g] <= RST_DATA;
        else if (conv_done && pairs_r[g/2])
          res_r[g] <= sample_i[g*DATA_W +: DATA_W];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read sequencing
  logic read_act;
  logic rd_prev_r;
  logic rd_end;
  logic byte_mode;
  logic [2:0] ch_r;
  logic half_r;
  logic [2:0] ch_nxt;
  logic [15:0] word;
  logic [15:0] bus_val;
  logic [15:0] db_r;
  logic oe_n_r;
  logic [5:0] avail;
  assign read_act = ~port.interface_select & ~port.cs_n & ~port.rd_n;
  assign rd_end = rd_prev_r & ~read_act;
  assign byte_mode = port.word_byte_sel;
  assign avail = {pairs_r[2], pairs_r[2], pairs_r[1], pairs_r[1],
    pairs_r[0], pairs_r[0]};

  // Next converted channel above the current one
  always_comb
  begin
    ch_nxt = ch_r;
    for (int i = NUM_CH - 1; i >= 0; i--)
      if (i > int'(ch_r) && avail[i])
        ch_nxt = 3'(i);
  end

  // First converted channel
  logic [2:0] ch_first;
  always_comb
  begin
    ch_first = RST_CH;
    for (int i = NUM_CH - 1; i >= 0; i--)
      if (avail[i])
        ch_first = 3'(i);
  end

  assign word = res_r[ch_r];
  assign bus_val = !byte_mode ? word :
    {((half_r ^ port.high_byte_first) ? word[15:8] : word[7:0]),
    8'h00};

  // Advance pointer when a read strobe ends; in byte mode only when the second byte's strobe ends
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_prev_r <= 1'b0;
      ch_r <= RST_CH;
      half_r <= 1'b0;
    end
    else
    begin
      rd_prev_r <= read_act;
      if (conv_done)
      begin
        ch_r <= ch_first;
        half_r <= 1'b0;
      end
      else if (rd_end)
      begin
        if (byte_mode && !half_r)
          half_r <= 1'b1;
        else
        begin
          half_r <= 1'b0;
          ch_r <= ch_nxt;
        end
      end
    end
  end

  // Registered bus drive
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      db_r <= RST_DATA;
      oe_n_r <= 1'b1;
    end
    else
    begin
      db_r <= read_act ? bus_val : RST_DATA;
      oe_n_r <= ~read_act;
    end
  end

  assign port.busy = busy_r;
  assign port.db_out = db_r;
  assign port.db_oe_n = oe_n_r;
  assign track_o = track_r;
  assign conv_pairs_o = pairs_r;
endmodule
`default_nettype wire

// >>> rtl/ssa_host.sv
// Host end: pulses start inputs and reads results; busy is never watched
`timescale 1ns/1ns
`default_nettype none
module ssa_host
(
  input wire logic clk_i,
  input wire logic rst_i,
  ssa_port_if.host port,
  input wire logic start_i,
  input wire logic read_i,
  input wire logic [2:0] pairs_i,
  input wire logic byte_mode_i,
  input wire logic high_first_i,
  input wire logic serial_i,
  output logic [15:0] data_o,
  output logic data_valid_o,
  output logic done_o
);
  import ssa_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state
  ssh_state_t state_r;
  logic [1:0] cnt_r;
  logic [2:0] start_n_r;
  logic rd_n_r;
  logic cs_n_r;
  logic sel_r;
  logic wb_r;
  logic hbf_r;
  logic [15:0] data_r;
  logic valid_r;
  logic done_r;
  logic hold_end;
  // Each strobe level and each gap lasts the same short count
  assign hold_end = (cnt_r == 2'(READ_IDLE - 1));

  // Mode pins follow the requests
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel_r <= 1'b0;
      wb_r <= 1'b0;
      hbf_r <= 1'b0;
    end
    else
    begin
      sel_r <= serial_i;
      wb_r <= byte_mode_i;
      hbf_r <= high_first_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start pulse and read strobe sequencing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= SSH_IDLE;
      cnt_r <= '0;
      start_n_r <= 3'h7;
      rd_n_r <= 1'b1;
      cs_n_r <= 1'b1;
      data_r <= RST_DATA;
      valid_r <= 1'b0;
      done_r <= 1'b1;
    end
    else
    begin
      valid_r <= 1'b0;
      case (state_r)
        SSH_IDLE:
        begin
          cnt_r <= '0;
          if (start_i)
          begin
            state_r <= SSH_START_LO;
            start_n_r <= ~pairs_i;
            done_r <= 1'b0;
          end
          else if (read_i)
          begin
            state_r <= SSH_READ_LO;
            cs_n_r <= 1'b0;
            rd_n_r <= 1'b0;
            done_r <= 1'b0;
          end
        end
        SSH_START_LO:
        begin
          if (hold_end)
          begin
            state_r <= SSH_GAP;
            cnt_r <= '0;
            start_n_r <= 3'h7;
          end
          else
            cnt_r <= cnt_r + 2'h1;
        end
        SSH_READ_LO:
        begin
          if (hold_end)
          begin
            state_r <= SSH_GAP;
            cnt_r <= '0;
            rd_n_r <= 1'b1;
            cs_n_r <= 1'b1;
            data_r <= port.db_out; // Registered bus has settled by now
            valid_r <= 1'b1;
          end
          else
            cnt_r <= cnt_r + 2'h1;
        end
        SSH_GAP:
        begin
          if (hold_end)
          begin
            state_r <= SSH_IDLE;
            cnt_r <= '0;
            done_r <= 1'b1;
          end
          else
            cnt_r <= cnt_r + 2'h1;
        end
        default: state_r <= SSH_IDLE;
      endcase
    end
  end

  // Pins and results straight from the registers
  assign port.pair1_start_n = start_n_r[0];
  assign port.pair2_start_n = start_n_r[1];
  assign port.pair3_start_n = start_n_r[2];
  assign port.cs_n = cs_n_r;
  assign port.rd_n = rd_n_r;
  assign port.interface_select = sel_r;
  assign port.word_byte_sel = wb_r;
  assign port.high_byte_first = hbf_r;
  assign data_o = data_r;
  assign data_valid_o = valid_r;
  assign done_o = done_r;
endmodule
`default_nettype wire

// >>> testbench/ssa_port_monitor.sv
// Checker for the converter parallel port signals
`timescale 1ns/1ns
`default_nettype none
module ssa_port_monitor
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pair1_start_n,
  input wire logic pair2_start_n,
  input wire logic pair3_start_n,
  input wire logic busy,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic interface_select,
  input wire logic [15:0] db_out,
  input wire logic db_oe_n
);
  import ssa_pkg::*;
  logic [7:0] cnt_r;
  logic [2:0] st_r;
  logic rise_r;
  logic rise2_r;
  wire [2:0] st = {pair3_start_n, pair2_start_n, pair1_start_n};
  wire rise_now = |(st & ~st_r);
  // Busy length counter and recent start edges
  always_ff @(posedge clk_i)
  begin
    st_r <= st;
    rise_r <= rise_now;
    rise2_r <= rise_r;
    cnt_r <= busy ? cnt_r + 8'h01 : 8'h00;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  oe_gate_a:
    assert property (!db_oe_n |->
      $past(!cs_n && !rd_n && !interface_select))
    else $error("bus driven");
  oe_on_a:
    assert property (!cs_n && !rd_n && !interface_select |-> ##[0:1] !db_oe_n)
    else $error("bus not driven in read");
  serial_off_a:
    assert property (interface_select |-> db_oe_n) else $error("serial drive");
  busy_rise_a:
    assert property (rise_now && !busy |-> ##[1:3] busy) else $error("no busy");
  busy_cause_a:
    assert property ($rose(busy) |-> rise_now || rise_r || rise2_r)
    else $error("busy without start");
  busy_len_a:
    assert property ($fell(busy) |-> cnt_r >= CONV_LAST
      && cnt_r <= CONV_CYCLES + 1) else $error("busy length");
  busy_hold_a:
    assert property ($rose(busy) |-> busy[*8]) else $error("busy short");
  data_stand_a:
    assert property (!db_oe_n && $past(!db_oe_n)
      |-> $stable(db_out)) else $error("read data moved");
  // Main scenarios
  cover property ($fell(busy));
  cover property (!db_oe_n);
  cover property (busy && rise_now);
endmodule
`default_nettype wire

// >>> testbench/test_sim_sample_adc_parallel_port.sv
// Self-checking bench for the converter parallel port
`timescale 1ns/1ns
`default_nettype none
module test_sim_sample_adc_parallel_port;
  import ssa_pkg::*;
  typedef struct packed {logic [2:0] pairs; logic byt; logic hif;} ssa_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] smp [6] = '{16'h8001, 16'h7ffe, 16'h1234, 16'hfedc,
    16'h0f0f, 16'hc3a5};
  // Rows: pairs started, byte mode, high byte first
  ssa_row_t rows [4] = '{5'h1c, 5'h14, 5'h0a, 5'h0f};
  logic [15:0] d;
  logic [15:0] e;
  logic start = 1'b0;
  logic read = 1'b0;
  logic [2:0] pairs = 3'h0;
  logic byt = 1'b0;
  logic hif = 1'b0;
  logic ser = 1'b0;
  logic [15:0] hdata;
  logic hvalid;
  logic hdone;
  int n_fail = 0;
  int total_checks = 0;
  logic track;
  logic [2:0] cpairs;
  ssa_port_if bus ();
  ssa_device i_ssa_device (.clk_i(clk_i), .rst_i(rst_i), .port(bus),
    .sample_i({smp[5], smp[4], smp[3], smp[2], smp[1], smp[0]}),
    .track_o(track), .conv_pairs_o(cpairs));
  ssa_host i_ssa_host (.clk_i(clk_i), .rst_i(rst_i), .port(bus),
    .start_i(start), .read_i(read), .pairs_i(pairs), .byte_mode_i(byt),
    .high_first_i(hif), .serial_i(ser), .data_o(hdata),
    .data_valid_o(hvalid), .done_o(hdone));
  ssa_port_monitor i_ssa_port_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .pair1_start_n(bus.pair1_start_n), .pair2_start_n(bus.pair2_start_n),
    .pair3_start_n(bus.pair3_start_n), .busy(bus.busy), .cs_n(bus.cs_n),
    .rd_n(bus.rd_n), .interface_select(bus.interface_select),
    .db_out(bus.db_out), .db_oe_n(bus.db_oe_n));
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  // Start pulse through the host, then wait until it is idle again
  task automatic conv(input logic [2:0] p);
    pairs = p;
    start = 1'b1;
    @(negedge clk_i);
    start = 1'b0;
    while (hdone !== 1'b1)
      @(negedge clk_i);
    check(16'(bus.busy), 16'h0001);
  endtask
  task automatic wait_done(input logic [2:0] p);
    for (int i = 0; i < 400 && bus.busy !== 1'b0; i++)
      @(negedge clk_i);
    @(negedge clk_i);
    check(16'(bus.busy), 16'h0000);
    check(16'(track), 16'h0001);
    check(16'(cpairs), 16'(p));
  endtask
  // One read strobe through the host; d takes the captured bus value
  task automatic rd(input logic oe_n_exp);
    read = 1'b1;
    @(negedge clk_i);
    read = 1'b0;
    while (hvalid !== 1'b1)
      @(negedge clk_i);
    d = hdata;
    check(16'(bus.db_oe_n), 16'(oe_n_exp));
    while (hdone !== 1'b1)
      @(negedge clk_i);
  endtask
  task automatic close_out;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    check(16'(bus.busy), 16'h0000);
    check(16'(bus.db_oe_n), 16'h0001);
    check(16'(track), 16'h0001);
    // Ordinary cases, one conversion and full readout per row
    foreach (rows[r])
    begin
      {byt, hif} = {rows[r].byt, rows[r].hif};
      conv(rows[r].pairs);
      wait_done(rows[r].pairs);
      for (int c = 0; c < 6; c++)
        for (int b = 0; b < (rows[r].pairs[c/2] ? 1 + rows[r].byt : 0); b++)
        begin
          rd(1'b0);
          e = 16'(8'(smp[c] >> (8 * (b ^ rows[r].hif))));
          if (!rows[r].byt)
            check(d, smp[c]);
          else
            check(16'(d[15:8]), e);
        end
      $display("row %0d done", r);
    end
    // Start edge while busy is ignored
    byt = 1'b0;
    conv(3'h1);
    conv(3'h4);
    wait_done(3'h1);
    rd(1'b0);
    check(d, smp[0]);
    rd(1'b0);
    check(d, smp[1]);
    // Partial readout, then a new conversion restarts the order
    conv(3'h6);
    wait_done(3'h6);
    rd(1'b0);
    check(d, smp[2]);
    conv(3'h2);
    wait_done(3'h2);
    rd(1'b0);
    check(d, smp[2]);
    // Serial select keeps the bus released and the order unmoved
    ser = 1'b1;
    rd(1'b1);
    check(d, RST_DATA);
    ser = 1'b0;
    rd(1'b0);
    check(d, smp[3]);
    // Reset in mid conversion ends it cleanly
    conv(3'h7);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    check(16'(bus.busy), 16'h0000);
    check(16'(cpairs), 16'h0000);
    $display("awkward cases done");
    close_out();
  end
  initial
  begin
    repeat (6000) @(posedge clk_i);
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
